// ### rtl/rioc_pkg.sv
// package for the relay i/o point conditioning block
// assumes a single 100 MHz clock domain and a plain register port
package rioc_pkg;
	localparam int CLK_MHZ = 100;
	// scan tick period, in microseconds
	localparam int SCAN_US = 500;
	localparam int SCAN_CYC = SCAN_US * CLK_MHZ;
	localparam int US_CYC = CLK_MHZ;
	localparam int N_CIN = 8;
	localparam int N_VIN = 32;
	localparam int N_COUT = 8;
	localparam int N_VOUT = 64;
	localparam int N_PAIR = 128;
	localparam int N_DNA = 32;
	localparam int N_USER = 32;
	localparam int N_DEV = 4;
	localparam int HOLD_MULT = 3;
	localparam int PASS_PER_CYC = 8;
	// register word indices (byte address = index * 4)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DEBOUNCE = 8'h01;
	localparam logic [7:0] REG_PASS_LEN = 8'h02;
	localparam logic [7:0] REG_VIN_EN = 8'h03;
	localparam logic [7:0] REG_VIN_LATCH = 8'h04;
	localparam logic [7:0] REG_VIN_CMD = 8'h05;
	localparam logic [7:0] REG_VIN_STATE = 8'h06;
	localparam logic [7:0] REG_CIN_STATE = 8'h07;
	localparam logic [7:0] REG_STAMP = 8'h08;
	localparam logic [7:0] REG_UPDATE_S = 8'h09;
	localparam logic [7:0] REG_DEV_SEL = 8'h0A;
	localparam logic [7:0] REG_OFFLINE = 8'h0B;
	localparam logic [7:0] REG_SBO = 8'h0C;
	localparam logic [7:0] REG_EVT_EN = 8'h0D;
	localparam logic [31:0] DEBOUNCE_RST = 32'h0000_0005;
	localparam logic [31:0] PASS_LEN_RST = 32'h0000_0D05;
	localparam logic [31:0] UPDATE_S_RST = 32'h0000_003C;
	localparam logic [31:0] SBO_RST = 32'h0000_0064;
endpackage : rioc_pkg

// ### rtl/rioc_nvram.sv
// small retained store for the virtual input states
// assumes contents survive loss of control power (backed storage)
`timescale 1ns/1ps
module rioc_nvram (
	input wire logic i_clock,
	input wire logic i_we,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata
);
	logic [31:0] mem;
	// no reset on purpose: this word must outlive a power loss
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem <= i_wdata;
		end
		o_rdata <= mem;
	end
endmodule : rioc_nvram

// ### rtl/rioc_top.sv
// relay i/o point conditioning: contact inputs, virtual i/o, remote points
// assumes equation engine and network stack outside; one 100 MHz clock
`timescale 1ns/1ps
// Operation
// - scan contact inputs every 0.5 ms
// - operand lags debounce plus at most one pass
// - late validation waits for next pass
// - eight protection passes per power cycle
// - stamp change with first new-state sample time
// - same debounce for rising and falling
// - 32 virtual inputs, zero until commanded
// - virtual input states saved, but restored as zero (vin_en, vin_latch still reset)
// - disabled virtual input held at zero
// - self-reset pulse lasts one pass
// - latched input follows latest command
// - select-before-operate timer auto de-selects
// - contact output operate or seal-in
// - contact output changes logged when enabled, unless a contact input event takes that cycle
// - 64 virtual outputs, zero when undriven
// - virtual output changes logged when enabled, unless a contact input or output event takes that cycle
// - 32 predefined plus 32 user pairs
// - send on power-up, change, or interval
// - hold time is three update intervals
// - accept only selected originators
// - hold timer expiry applies default states
// - accepted message updates points, restarts timer
// - level must stay stable whole debounce time
// - operand updated at pass start
module rioc_top (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [rioc_pkg::N_CIN-1:0] i_contact,
	output logic [rioc_pkg::N_CIN-1:0] o_cin_operand,
	output logic o_pass_start,
	output logic [rioc_pkg::N_VIN-1:0] o_vin_operand,
	input wire logic [rioc_pkg::N_COUT-1:0] i_cout_operate,
	input wire logic [rioc_pkg::N_COUT-1:0] i_cout_seal,
	output logic [rioc_pkg::N_COUT-1:0] o_cout,
	input wire logic [rioc_pkg::N_VOUT-1:0] i_vout_eqn,
	input wire logic [rioc_pkg::N_VOUT-1:0] i_vout_assigned,
	output logic [rioc_pkg::N_VOUT-1:0] o_vout,
	output logic o_event,
	output logic [1:0] o_event_kind,
	output logic [31:0] o_event_stamp,
	input wire logic [rioc_pkg::N_DNA-1:0] i_dna_pair,
	input wire logic [rioc_pkg::N_USER-1:0] i_user_status_pair,
	output logic o_tx_send,
	output logic [2*rioc_pkg::N_PAIR-1:0] o_tx_pairs,
	output logic [31:0] o_tx_hold_s,
	input wire logic i_rx_valid,
	input wire logic [1:0] i_rx_dev,
	input wire logic i_rx_dev_match,
	input wire logic [31:0] i_rx_hold_s,
	input wire logic [63:0] i_rx_points,
	input wire logic [63:0] i_rx_default,
	output logic [rioc_pkg::N_DEV*64-1:0] o_remote_points,
	output logic [rioc_pkg::N_DEV-1:0] o_offline
);
	localparam int SCW = $clog2(rioc_pkg::SCAN_CYC);
	logic [SCW-1:0] scan_cnt;
	logic scan_tick;
	logic [6:0] us_cnt;
	logic us_tick;
	logic [31:0] now_us;
	logic [31:0] debounce;
	logic [31:0] pass_len;
	logic [31:0] pass_cnt;
	logic [31:0] vin_en;
	logic [31:0] vin_latch;
	logic [31:0] vin_cmd;
	logic [31:0] vin_prev_cmd;
	logic [31:0] vin_state;
	logic [31:0] nv_rdata;
	logic nv_loaded;
	logic [31:0] update_s;
	logic [3:0] dev_sel;
	logic [31:0] sbo_len;
	logic [31:0] sbo_cnt;
	logic [3:0] evt_en;
	logic [31:0] stamp_last;
	logic [31:0] sec_cnt;

	// contact pin synchroniser: second stage is the only reader of first
	logic [rioc_pkg::N_CIN-1:0] sync1;
	logic [rioc_pkg::N_CIN-1:0] sync2;
	always_ff @(posedge i_clock) begin
		sync1 <= i_contact;
		sync2 <= sync1;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n || scan_tick) begin
			scan_cnt <= '0;
		end else begin
			scan_cnt <= scan_cnt + 1'b1;
		end
	end
	assign scan_tick = (scan_cnt == SCW'(rioc_pkg::SCAN_CYC - 1));

	// microsecond time base for stamps and for the update and hold timers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || us_tick) begin
			us_cnt <= '0;
		end else begin
			us_cnt <= us_cnt + 1'b1;
		end
	end
	assign us_tick = (us_cnt == 7'(rioc_pkg::US_CYC - 1));
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			now_us <= '0;
		end else if (us_tick) begin
			now_us <= now_us + 32'h0000_0001;
		end
	end

	// pass period set by the pass length register (cycle length / 8)
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || o_pass_start) begin
			pass_cnt <= '0;
		end else begin
			pass_cnt <= pass_cnt + 32'h0000_0001;
		end
	end
	assign o_pass_start = (pass_cnt >= pass_len - 32'h0000_0001);

	// debounce per input; candidate, count of agreeing scans, stamp
	logic [rioc_pkg::N_CIN-1:0] valid_state;
	logic [rioc_pkg::N_CIN-1:0] pend;
	logic [7:0] cnt [rioc_pkg::N_CIN];
	logic [31:0] first_us [rioc_pkg::N_CIN];
	logic [rioc_pkg::N_CIN-1:0] validate;
	// a zero debounce validates on the first new-state sample
	// before first_us is written, so that stamp comes from now_us
	logic [31:0] stamp_of [rioc_pkg::N_CIN];
	always_comb begin
		for (int i = 0; i < rioc_pkg::N_CIN; i++) begin
			validate[i] = scan_tick && (sync2[i] != valid_state[i]) &&
				(32'(cnt[i]) + 32'h0000_0001 >= debounce + 32'h0000_0001);
			stamp_of[i] = (cnt[i] == 8'h00) ? now_us : first_us[i];
		end
	end
	// stable for whole debounce time; symmetric; restart
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			valid_state <= '0;
			for (int i = 0; i < rioc_pkg::N_CIN; i++) begin
				cnt[i] <= '0;
				first_us[i] <= '0;
			end
		end else if (scan_tick) begin
			for (int i = 0; i < rioc_pkg::N_CIN; i++) begin
				if (sync2[i] == valid_state[i]) begin
					cnt[i] <= '0;
				end else if (validate[i]) begin
					valid_state[i] <= sync2[i];
					cnt[i] <= '0;
				end else begin
					// stamp held from the first new-state sample
					if (cnt[i] == 8'h00) begin
						first_us[i] <= now_us;
					end
					cnt[i] <= cnt[i] + 8'h01;
				end
			end
		end
	end

	// operand refreshed at pass start; late change waits
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_cin_operand <= '0;
		end else if (o_pass_start) begin
			o_cin_operand <= valid_state;
		end
	end

	// retained virtual input word, reloaded once after reset but masked by vin_en and vin_latch, still zero then
	rioc_nvram u_nv (
		.i_clock(i_clock),
		.i_we(nv_loaded),
		.i_wdata(vin_state),
		.o_rdata(nv_rdata)
	);

	// states zero until command; disabled; pulse; latch
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			vin_state <= '0;
			vin_prev_cmd <= '0;
			nv_loaded <= 1'b0;
			o_vin_operand <= '0;
		end else if (!nv_loaded) begin
			vin_state <= nv_rdata & vin_en & vin_latch;
			nv_loaded <= 1'b1;
		end else if (o_pass_start) begin
			vin_prev_cmd <= vin_cmd;
			for (int i = 0; i < rioc_pkg::N_VIN; i++) begin
				if (!vin_en[i]) begin
					vin_state[i] <= 1'b0;
					o_vin_operand[i] <= 1'b0;
				end else if (vin_latch[i]) begin
					vin_state[i] <= vin_cmd[i];
					o_vin_operand[i] <= vin_cmd[i];
				end else begin
					vin_state[i] <= 1'b0;
					o_vin_operand[i] <= vin_cmd[i] & ~vin_prev_cmd[i];
				end
			end
		end
	end

	logic sbo_selected;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sbo_selected <= 1'b0;
			sbo_cnt <= '0;
		end else if (i_wr && i_addr == rioc_pkg::REG_VIN_CMD) begin
			sbo_selected <= 1'b1;
			sbo_cnt <= sbo_len;
		end else if (sbo_selected && us_tick) begin
			if (sbo_cnt <= 32'h0000_0001) begin
				sbo_selected <= 1'b0;
			end
			sbo_cnt <= sbo_cnt - 32'h0000_0001;
		end
	end

	// operate or seal-in; virtual outputs each pass
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_cout <= '0;
			o_vout <= '0;
		end else if (o_pass_start) begin
			o_cout <= i_cout_operate | (i_cout_seal & o_cout);
			o_vout <= i_vout_eqn & i_vout_assigned;
		end
	end

	// event pulse, one per cycle; contact inputs win, then contact outputs, then virtual outputs
	logic [rioc_pkg::N_COUT-1:0] cout_d;
	logic [rioc_pkg::N_VOUT-1:0] vout_d;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cout_d <= '0;
			vout_d <= '0;
			o_event <= 1'b0;
			o_event_kind <= 2'h0;
			o_event_stamp <= '0;
			stamp_last <= '0;
		end else begin
			cout_d <= o_cout;
			vout_d <= o_vout;
			o_event <= 1'b0;
			if (evt_en[0] && |validate) begin
				o_event <= 1'b1;
				o_event_kind <= 2'h0;
				for (int i = rioc_pkg::N_CIN - 1; i >= 0; i--) begin
					if (validate[i]) begin
						o_event_stamp <= stamp_of[i];
						stamp_last <= stamp_of[i];
					end
				end
			end else if (evt_en[1] && (cout_d != o_cout)) begin
				o_event <= 1'b1;
				o_event_kind <= 2'h1;
				o_event_stamp <= now_us;
			end else if (evt_en[2] && (vout_d != o_vout)) begin
				o_event <= 1'b1;
				o_event_kind <= 2'h2;
				o_event_stamp <= now_us;
			end
		end
	end

	// send on power-up, on change of a pair, else on interval
	logic [rioc_pkg::N_DNA-1:0] dna_d;
	logic [rioc_pkg::N_USER-1:0] user_d;
	logic boot_sent;
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dna_d <= '0;
			user_d <= '0;
			boot_sent <= 1'b0;
			sec_cnt <= '0;
			o_tx_send <= 1'b0;
		end else begin
			dna_d <= i_dna_pair;
			user_d <= i_user_status_pair;
			o_tx_send <= 1'b0;
			if (!boot_sent || dna_d != i_dna_pair ||
				user_d != i_user_status_pair ||
				sec_cnt >= update_s * 32'd1000000) begin
				o_tx_send <= 1'b1;
				boot_sent <= 1'b1;
				sec_cnt <= '0;
			end else if (us_tick) begin
				sec_cnt <= sec_cnt + 32'h0000_0001;
			end
		end
	end
	// 32 dna and 32 user pairs as true/complement, rest zero
	always_comb begin
		o_tx_pairs = '0;
		for (int i = 0; i < rioc_pkg::N_DNA; i++) begin
			o_tx_pairs[2*i +: 2] = {i_dna_pair[i], ~i_dna_pair[i]};
			o_tx_pairs[2*(rioc_pkg::N_DNA+i) +: 2] =
				{i_user_status_pair[i], ~i_user_status_pair[i]};
		end
	end
	assign o_tx_hold_s = update_s * 32'(rioc_pkg::HOLD_MULT);

	logic [31:0] hold_us [rioc_pkg::N_DEV];
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_offline <= '1;
			o_remote_points <= '0;
			for (int d = 0; d < rioc_pkg::N_DEV; d++) begin
				hold_us[d] <= '0;
			end
		end else begin
			for (int d = 0; d < rioc_pkg::N_DEV; d++) begin
				if (i_rx_valid && i_rx_dev_match && dev_sel[d] &&
					i_rx_dev == 2'(d)) begin
					hold_us[d] <= i_rx_hold_s * 32'd1000000;
					o_offline[d] <= 1'b0;
					o_remote_points[64*d +: 64] <= i_rx_points;
				end else if (hold_us[d] != 32'h0 && us_tick) begin
					hold_us[d] <= hold_us[d] - 32'h0000_0001;
				end else if (hold_us[d] == 32'h0) begin
					o_offline[d] <= 1'b1;
					o_remote_points[64*d +: 64] <= i_rx_default;
				end
			end
		end
	end

	// register writes
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			debounce <= rioc_pkg::DEBOUNCE_RST;
			pass_len <= rioc_pkg::PASS_LEN_RST;
			vin_en <= '0;
			vin_latch <= '0;
			vin_cmd <= '0;
			update_s <= rioc_pkg::UPDATE_S_RST;
			dev_sel <= '0;
			sbo_len <= rioc_pkg::SBO_RST;
			evt_en <= '0;
		end else if (i_wr) begin
			if (i_addr == rioc_pkg::REG_DEBOUNCE) begin
				debounce <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_PASS_LEN) begin
				pass_len <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_VIN_EN) begin
				vin_en <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_VIN_LATCH) begin
				vin_latch <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_VIN_CMD) begin
				vin_cmd <= i_wdata & vin_en;
			end else if (i_addr == rioc_pkg::REG_UPDATE_S) begin
				update_s <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_DEV_SEL) begin
				dev_sel <= i_wdata[3:0];
			end else if (i_addr == rioc_pkg::REG_SBO) begin
				sbo_len <= i_wdata;
			end else if (i_addr == rioc_pkg::REG_EVT_EN) begin
				evt_en <= i_wdata[3:0];
			end
		end
	end

	// register reads, unmapped reads as zero
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			if (i_addr == rioc_pkg::REG_CTRL) begin
				o_rdata <= {31'h0, sbo_selected};
			end else if (i_addr == rioc_pkg::REG_DEBOUNCE) begin
				o_rdata <= debounce;
			end else if (i_addr == rioc_pkg::REG_PASS_LEN) begin
				o_rdata <= pass_len;
			end else if (i_addr == rioc_pkg::REG_UPDATE_S) begin
				o_rdata <= update_s;
			end else if (i_addr == rioc_pkg::REG_VIN_STATE) begin
				o_rdata <= o_vin_operand;
			end else if (i_addr == rioc_pkg::REG_CIN_STATE) begin
				o_rdata <= {24'h0, o_cin_operand};
			end else if (i_addr == rioc_pkg::REG_STAMP) begin
				o_rdata <= stamp_last;
			end else if (i_addr == rioc_pkg::REG_OFFLINE) begin
				o_rdata <= {28'h0, o_offline};
			end else begin
				o_rdata <= '0;
			end
		end else begin
			o_rdata <= '0;
		end
	end

	// seal-in only holds an already energised output
	seal_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_pass_start && !i_cout_operate[0] && !o_cout[0]
		|=> !o_cout[0]) else $error("seal-in energised idle output");
	vout_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_pass_start && !i_vout_assigned[0] |=> !o_vout[0])
		else $error("unassigned virtual output high");
	vin_dis_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_pass_start && nv_loaded && !vin_en[0] |=> !o_vin_operand[0])
		else $error("disabled virtual input high");
	// contact operand only moves at a pass start
	cin_pass_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!$past(o_pass_start) |-> $stable(o_cin_operand))
		else $error("contact operand moved off pass");
	hold_three_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_tx_hold_s == update_s * 32'd3)
		else $error("hold time not three intervals");
	scan_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		scan_tick |=> !scan_tick [*8])
		else $error("scan ticks too close");
	online_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_rx_valid && i_rx_dev_match && dev_sel[0] && i_rx_dev == 2'h0
		&& i_rx_hold_s != 32'h0 |=> !o_offline[0])
		else $error("offline not cleared");
	// power-up send within two cycles of reset release
	boot_send_a: assert property (@(posedge i_clock)
		$rose(i_rst_n) |-> ##[0:2] o_tx_send)
		else $error("no power-up message");
endmodule : rioc_top

// ### verif/rioc_peer_model.sv
// stand-in for the field contacts and one peer relay on the lan
// assumes the bench calls send_msg just after a rising clock edge
`timescale 1ns/1ps
module rioc_peer_model (
	input wire logic i_clock,
	output logic [7:0] o_contact,
	output logic o_rx_valid,
	output logic [1:0] o_rx_dev,
	output logic o_rx_dev_match,
	output logic [31:0] o_rx_hold_s,
	output logic [63:0] o_rx_points,
	output logic [63:0] o_rx_default
);
	// contacts start open; default states are configuration, held steady
	initial begin
		o_contact = 8'h00;
		o_rx_valid = 1'b0;
		o_rx_dev = 2'h0;
		o_rx_dev_match = 1'b0;
		o_rx_hold_s = 32'h0000_0000;
		o_rx_points = 64'h0000_0000_0000_0000;
		o_rx_default = 64'h0000_0000_0F0F_0F0F;
	end
	// one message is one valid cycle; match, hold and points are inverted afterwards so
	// a receiver that samples late picks up wrong data and is caught
	task automatic send_msg(input logic [1:0] dev, input logic match,
		input logic [31:0] hold, input logic [63:0] pts);
		o_rx_valid <= 1'b1;
		o_rx_dev <= dev;
		o_rx_dev_match <= match;
		o_rx_hold_s <= hold;
		o_rx_points <= pts;
		@(posedge i_clock);
		o_rx_valid <= 1'b0;
		o_rx_dev_match <= ~match;
		o_rx_hold_s <= ~hold;
		o_rx_points <= ~pts;
	endtask : send_msg
	// contacts change off the scan edge; the bench picks the moment
	task automatic set_contact(input logic [7:0] level);
		o_contact <= level;
	endtask : set_contact
endmodule : rioc_peer_model

// ### verif/tb.sv
// self-checking bench for the relay i/o point conditioning block
// assumes one 100 MHz clock and the register port of the block
`timescale 1ns/1ps
module tb;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_cout_operate = 8'h00;
	logic [7:0] i_cout_seal = 8'h00;
	logic [63:0] i_vout_eqn = 64'h0000_0000_0000_0000;
	logic [63:0] i_vout_assigned = 64'h0000_0000_0000_0000;
	logic [31:0] i_dna_pair = 32'h0000_0000;
	logic [31:0] i_user_status_pair = 32'h0000_0000;
	logic [31:0] o_rdata, o_event_stamp, o_tx_hold_s, i_rx_hold_s;
	logic [7:0] i_contact, o_cin_operand, o_cout;
	logic [31:0] o_vin_operand;
	logic [63:0] o_vout, i_rx_points, i_rx_default;
	logic [255:0] o_tx_pairs, o_remote_points;
	logic [1:0] o_event_kind, i_rx_dev;
	logic [3:0] o_offline;
	logic o_pass_start, o_event, o_tx_send, i_rx_valid, i_rx_dev_match;
	int err_total = 0;
	int total_checks = 0;
	// free running clock
	always #5 i_clock = ~i_clock;
	rioc_top u_rioc_top (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_contact(i_contact),
		.o_cin_operand(o_cin_operand), .o_pass_start(o_pass_start),
		.o_vin_operand(o_vin_operand), .i_cout_operate(i_cout_operate),
		.i_cout_seal(i_cout_seal), .o_cout(o_cout),
		.i_vout_eqn(i_vout_eqn), .i_vout_assigned(i_vout_assigned),
		.o_vout(o_vout), .o_event(o_event), .o_event_kind(o_event_kind),
		.o_event_stamp(o_event_stamp), .i_dna_pair(i_dna_pair),
		.i_user_status_pair(i_user_status_pair), .o_tx_send(o_tx_send),
		.o_tx_pairs(o_tx_pairs), .o_tx_hold_s(o_tx_hold_s),
		.i_rx_valid(i_rx_valid), .i_rx_dev(i_rx_dev),
		.i_rx_dev_match(i_rx_dev_match), .i_rx_hold_s(i_rx_hold_s),
		.i_rx_points(i_rx_points), .i_rx_default(i_rx_default),
		.o_remote_points(o_remote_points), .o_offline(o_offline));
	rioc_peer_model u_rioc_peer_model (.i_clock(i_clock),
		.o_contact(i_contact), .o_rx_valid(i_rx_valid),
		.o_rx_dev(i_rx_dev), .o_rx_dev_match(i_rx_dev_match),
		.o_rx_hold_s(i_rx_hold_s), .o_rx_points(i_rx_points),
		.o_rx_default(i_rx_default));
	task automatic check_word(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp, input string what);
		check_word({63'h0, got}, {63'h0, exp}, what);
	endtask : check_bit
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : reg_wr
	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : reg_rd
	// returns just after the edge that acts on a pass start
	task automatic wait_pass();
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 100 && !seen; n++) begin
			@(negedge i_clock);
			seen = (o_pass_start === 1'b1);
		end
		check_bit(seen, 1'b1, "pass start");
		@(posedge i_clock);
		#1;
	endtask : wait_pass
	task automatic wait_event(input logic [1:0] kind, output logic seen);
		seen = 1'b0;
		for (int n = 0; n < 100 && !seen; n++) begin
			@(negedge i_clock);
			seen = (o_event === 1'b1) && (o_event_kind === kind);
		end
	endtask : wait_event
	task automatic test_reset();
		logic [31:0] d;
		check_word(o_offline, 4'hF, "offline after reset");
		check_word(o_vin_operand, 32'h0, "vin after reset");
		reg_rd(rioc_pkg::REG_DEBOUNCE, d);
		check_word(d, rioc_pkg::DEBOUNCE_RST, "debounce reset");
		reg_rd(rioc_pkg::REG_PASS_LEN, d);
		check_word(d, rioc_pkg::PASS_LEN_RST, "pass length reset");
		reg_rd(rioc_pkg::REG_UPDATE_S, d);
		check_word(d, rioc_pkg::UPDATE_S_RST, "update interval reset");
		reg_rd(8'h3F, d);
		check_word(d, 32'h0, "unmapped read");
		$display("test reset done");
	endtask : test_reset
	// short pass keeps the run brief; expectations count in passes
	task automatic test_vin();
		reg_wr(rioc_pkg::REG_PASS_LEN, 32'h0000_0014);
		reg_wr(rioc_pkg::REG_VIN_EN, 32'h0000_0003);
		reg_wr(rioc_pkg::REG_VIN_LATCH, 32'h0000_0001);
		reg_wr(rioc_pkg::REG_VIN_CMD, 32'h0000_0007);
		wait_pass();
		check_bit(o_vin_operand[0], 1'b1, "latched set");
		check_bit(o_vin_operand[1], 1'b1, "self reset pulse");
		check_bit(o_vin_operand[2], 1'b0, "disabled held");
		wait_pass();
		check_bit(o_vin_operand[0], 1'b1, "latched holds");
		check_bit(o_vin_operand[1], 1'b0, "self reset ends");
		reg_wr(rioc_pkg::REG_VIN_CMD, 32'h0000_0000);
		wait_pass();
		check_bit(o_vin_operand[0], 1'b0, "latched clear");
		$display("test vin done");
	endtask : test_vin
	task automatic test_vout();
		logic seen;
		reg_wr(rioc_pkg::REG_EVT_EN, 32'h0000_0004);
		@(posedge i_clock);
		i_vout_eqn <= 64'hFFFF_0000_FFFF_FFFF;
		i_vout_assigned <= 64'h0000_0000_0000_00FF;
		wait_pass();
		wait_pass();
		check_word(o_vout, 64'h0000_0000_0000_00FF, "vout masked");
		@(posedge i_clock);
		i_vout_eqn <= 64'h0000_0000_0000_0000;
		wait_event(2'h2, seen);
		check_bit(seen, 1'b1, "vout event");
		$display("test vout done");
	endtask : test_vout
	task automatic test_cout();
		logic seen;
		reg_wr(rioc_pkg::REG_EVT_EN, 32'h0000_0002);
		@(posedge i_clock);
		i_cout_operate <= 8'h01;
		i_cout_seal <= 8'h01;
		wait_pass();
		wait_pass();
		check_bit(o_cout[0], 1'b1, "operate");
		@(posedge i_clock);
		i_cout_operate <= 8'h00;
		wait_pass();
		wait_pass();
		check_bit(o_cout[0], 1'b1, "sealed in");
		@(posedge i_clock);
		i_cout_seal <= 8'h00;
		wait_event(2'h1, seen);
		check_bit(seen, 1'b1, "cout event");
		check_bit(o_cout[0], 1'b0, "seal released");
		$display("test cout done");
	endtask : test_cout
	task automatic test_remote();
		reg_wr(rioc_pkg::REG_DEV_SEL, 32'h0000_000F);
		@(posedge i_clock);
		u_rioc_peer_model.send_msg(2'h0, 1'b1, 32'h9, 64'hA5A5_0000_1234_5678);
		// let the release stand a cycle before the next message
		@(posedge i_clock);
		u_rioc_peer_model.send_msg(2'h1, 1'b0, 32'h9, 64'hFFFF_FFFF_FFFF_FFFF);
		repeat (3) @(posedge i_clock);
		#1;
		check_word(o_remote_points[63:0], 64'hA5A5_0000_1234_5678, "points");
		check_bit(o_offline[0], 1'b0, "online again");
		check_bit(o_offline[1], 1'b1, "foreign ignored");
		check_word(o_remote_points[127:64], 64'h0000_0000_0F0F_0F0F,
			"default points");
		$display("test remote done");
	endtask : test_remote
	task automatic test_tx();
		logic seen;
		reg_wr(rioc_pkg::REG_UPDATE_S, 32'h0000_0001);
		#1;
		check_word(o_tx_hold_s, 32'h0000_0003, "hold time");
		@(posedge i_clock);
		i_dna_pair <= 32'h0000_0001;
		i_user_status_pair <= 32'h8000_0000;
		seen = 1'b0;
		for (int n = 0; n < 100 && !seen; n++) begin
			@(negedge i_clock);
			seen = (o_tx_send === 1'b1);
		end
		check_bit(seen, 1'b1, "send on change");
		check_word(o_tx_pairs[1:0], 2'b10, "first pair");
		check_word(o_tx_pairs[65:64], 2'b01, "first user pair");
		check_word(o_tx_pairs[127:126], 2'b10, "last user pair");
		$display("test tx done");
	endtask : test_tx
	// zero debounce validates on the first scan, about 0.5 ms after reset
	task automatic test_cin();
		logic [31:0] d;
		logic [31:0] st;
		int n;
		reg_wr(rioc_pkg::REG_DEBOUNCE, 32'h0000_0000);
		reg_wr(rioc_pkg::REG_EVT_EN, 32'h0000_0001);
		u_rioc_peer_model.set_contact(8'h01);
		st = 32'hFFFF_FFFF;
		n = 0;
		while (n < rioc_pkg::SCAN_CYC + 100 &&
			o_cin_operand[0] !== 1'b1) begin
			@(negedge i_clock);
			if (o_event === 1'b1 && o_event_kind === 2'h0)
				st = o_event_stamp;
			n++;
		end
		check_bit(o_cin_operand[0], 1'b1, "contact operand");
		check_bit(st >= rioc_pkg::SCAN_US - 1 && st <= rioc_pkg::SCAN_US,
			1'b1, "event stamp");
		reg_rd(rioc_pkg::REG_STAMP, d);
		check_bit(d >= rioc_pkg::SCAN_US - 1 && d <= rioc_pkg::SCAN_US,
			1'b1, "stamp register");
		reg_rd(rioc_pkg::REG_CIN_STATE, d);
		check_word(d, 32'h0000_0001, "contact state");
		$display("test cin done");
	endtask : test_cin
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		repeat (16) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		#1;
		test_reset();
		test_vin();
		test_vout();
		test_cout();
		test_remote();
		test_tx();
		test_cin();
		tally_and_finish();
	end
	// hang guard: the contact test waits one scan, about 50k cycles
	initial begin
		#700000;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb
